// *** design/tps_seq.sv ***
// The address-and-strobe port and the address map are this design's own decisions.
`include "tps_defs.svh"

// Contract
// - Power-good waits hold-off after primary good.
// - Power-good drops at once on primary fail.
// - Primary gate follows its enable input.
// - No core/io sequencing before power-good.
// - IO and core gates off below lockout.
// - Sequence-enable rising edge turns core gate on.
// - Time mode: io on after up delay.
// - Enable falling: io off, core after down.
// - Set rising edge turns core gate on.
// - Voltage mode: io on when feedback exceeds reference.
// - Feedback comparison has hysteresis.
// - Set falling: io off, core after down.
// - Primary fail turns all gates off together.
// - IO fail: io off, core after down.
// - Core fail turns core and io off.
// - Status bits mirror gate control signals.
// - Status readable; three select pins address device.
// - Shutdown register overrides gate control.
// - Codes 01,02,03 shut down; 00 releases.
// - Status bits 3,2,1 gates, bit0 latch.
// - Shutdown writes ignored while latch clear.
module tps_seq
  import tps_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYC = `TPS_HOLDOFF_US * 1000 / `TPS_CLK_PERIOD_NS,
  parameter int unsigned SEQ_UP_CYC = `TPS_SEQ_UP_US * 1000 / `TPS_CLK_PERIOD_NS,
  parameter int unsigned SEQ_DOWN_CYC = `TPS_SEQ_DOWN_US * 1000 / `TPS_CLK_PERIOD_NS,
  parameter int unsigned CNT_W = 16,
  parameter int unsigned FB_W = `TPS_FB_W,
  parameter logic [FB_W-1:0] HYST_LSB = `TPS_HYST_LSB
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic primary_supply_ok_i,
  input wire logic io_supply_ok_i,
  input wire logic core_supply_ok_i,
  input wire logic primary_gate_enable_i,
  input wire logic sequence_enable_i,
  input wire logic voltage_sequence_set_i,
  input wire logic [FB_W-1:0] core_feedback_i,
  input wire logic [FB_W-1:0] core_reference_i,
  input wire logic [2:0] addr_pins_i,
  input wire logic [2:0] bus_dev_sel_i,
  input wire logic [`TPS_ADDR_W-1:0] bus_addr_i,
  input wire logic [`TPS_DATA_W-1:0] bus_wdata_i,
  input wire logic bus_we_i,
  input wire logic bus_re_i,
  output logic [`TPS_DATA_W-1:0] bus_rdata_o,
  output logic bus_wr_ack_o,
  output logic power_good_o,
  output logic primary_gate_o,
  output logic io_gate_o,
  output logic core_gate_o
);

  localparam logic [CNT_W-1:0] HOLDOFF_LIM = CNT_W'(HOLDOFF_CYC);
  localparam logic [CNT_W-1:0] UP_LIM = CNT_W'(SEQ_UP_CYC);
  localparam logic [CNT_W-1:0] DOWN_LIM = CNT_W'(SEQ_DOWN_CYC);

  // Returns {primary_off, io_core_off} for a shutdown code.
  function automatic logic [1:0] shutdown_decode(input logic [1:0] code);
    case (code)
      `TPS_SD_IO_CORE: shutdown_decode = 2'b01;
      `TPS_SD_PRIMARY: shutdown_decode = 2'b10;
      `TPS_SD_ALL: shutdown_decode = 2'b11;
      default: shutdown_decode = 2'b00;
    endcase
  endfunction

  logic rst_meta_r;
  logic rst_n;
  logic [CNT_W-1:0] hold_cnt_r;
  logic pg_r;
  logic ens_prev_r;
  logic voltage_sequence_set_in_prev_r;
  logic run_r;
  logic run_now;
  tps_mode_t mode_r;
  tps_mode_t mode_now;
  logic fb_above_r;
  tps_state_t state_r;
  logic [CNT_W-1:0] seq_cnt_r;
  logic core_r;
  logic io_r;
  logic wel_r;
  logic [`TPS_DATA_W-1:0] shutdown_r;
  logic primary_off;
  logic io_core_off;
  logic want_on;
  logic dev_hit;
  logic ens_rise;
  logic ens_fall;
  logic voltage_sequence_set_in_rise;
  logic voltage_sequence_set_in_fall;
  logic supplies_lost;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Hold-off restarts from zero on every dip of the primary supply.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_r <= '0;
      pg_r <= 1'b0;
    end else if (en_i) begin
      if (!primary_supply_ok_i) begin
        hold_cnt_r <= '0;
        pg_r <= 1'b0;
      end else if (hold_cnt_r < HOLDOFF_LIM) begin
        hold_cnt_r <= hold_cnt_r + 1'b1;
      end else begin
        pg_r <= 1'b1;
      end
    end
  end

  // The supply term makes the drop immediate rather than one cycle late.
  assign power_good_o = pg_r & primary_supply_ok_i;

  assign {primary_off, io_core_off} = shutdown_decode(shutdown_r[1:0]);
  assign primary_gate_o = primary_gate_enable_i & primary_supply_ok_i & ~primary_off;

  assign ens_rise = sequence_enable_i & ~ens_prev_r;
  assign ens_fall = ~sequence_enable_i & ens_prev_r;
  assign voltage_sequence_set_in_rise = voltage_sequence_set_i & ~voltage_sequence_set_in_prev_r;
  assign voltage_sequence_set_in_fall = ~voltage_sequence_set_i & voltage_sequence_set_in_prev_r;

  // Only the falling edge of the input that set the current mode, or an I/O failure while all on, may stop it.
  always_comb begin
    run_now = run_r;
    mode_now = mode_r;
    if (ens_rise) begin
      run_now = 1'b1;
      mode_now = TPS_MODE_TIME;
    end else if (voltage_sequence_set_in_rise) begin
      run_now = 1'b1;
      mode_now = TPS_MODE_VOLTAGE;
    end else if ((ens_fall && mode_r == TPS_MODE_TIME) || (voltage_sequence_set_in_fall && mode_r == TPS_MODE_VOLTAGE)) begin
      run_now = 1'b0;
    end else if (state_r == TPS_ALL_ON && !io_supply_ok_i) begin
      // An I/O failure drops the request, or the core would come back on right after the down delay.
      run_now = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ens_prev_r <= 1'b0;
      voltage_sequence_set_in_prev_r <= 1'b0;
      run_r <= 1'b0;
      mode_r <= TPS_MODE_TIME;
    end else if (en_i) begin
      ens_prev_r <= sequence_enable_i;
      voltage_sequence_set_in_prev_r <= voltage_sequence_set_i;
      run_r <= run_now;
      mode_r <= mode_now;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fb_above_r <= 1'b0;
    end else if (en_i) begin
      if (core_feedback_i > core_reference_i) begin
        fb_above_r <= 1'b1;
      end else if ({1'b0, core_feedback_i} + {1'b0, HYST_LSB} < {1'b0, core_reference_i}) begin
        fb_above_r <= 1'b0;
      end
    end
  end

  assign supplies_lost = ~pg_r | ~primary_supply_ok_i | ~core_supply_ok_i;
  assign want_on = run_now & ~io_core_off;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TPS_IDLE;
      seq_cnt_r <= '0;
      core_r <= 1'b0;
      io_r <= 1'b0;
    end else if (en_i) begin
      case (state_r)
        TPS_IDLE: begin
          if (want_on && !supplies_lost) begin
            state_r <= TPS_CORE_UP;
            core_r <= 1'b1;
            seq_cnt_r <= '0;
          end
        end
        TPS_CORE_UP: begin
          if (supplies_lost) begin
            state_r <= TPS_IDLE;
            core_r <= 1'b0;
          end else if (!want_on) begin
            state_r <= TPS_CORE_DOWN;
            seq_cnt_r <= '0;
          end else if (mode_r == TPS_MODE_TIME) begin
            if (seq_cnt_r < UP_LIM) begin
              seq_cnt_r <= seq_cnt_r + 1'b1;
            end else if (io_supply_ok_i) begin
              state_r <= TPS_ALL_ON;
              io_r <= 1'b1;
            end
          end else if (fb_above_r && io_supply_ok_i) begin
            state_r <= TPS_ALL_ON;
            io_r <= 1'b1;
          end
        end
        TPS_ALL_ON: begin
          if (supplies_lost) begin
            state_r <= TPS_IDLE;
            core_r <= 1'b0;
            io_r <= 1'b0;
          end else if (!want_on || !io_supply_ok_i) begin
            state_r <= TPS_CORE_DOWN;
            io_r <= 1'b0;
            seq_cnt_r <= '0;
          end
        end
        TPS_CORE_DOWN: begin
          if (supplies_lost || seq_cnt_r >= DOWN_LIM) begin
            state_r <= TPS_IDLE;
            core_r <= 1'b0;
          end else begin
            seq_cnt_r <= seq_cnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= TPS_IDLE;
          core_r <= 1'b0;
          io_r <= 1'b0;
        end
      endcase
    end
  end

  // Supply terms cut the gates in the same cycle as the failure.
  assign core_gate_o = core_r & core_supply_ok_i & primary_supply_ok_i;
  assign io_gate_o = io_r & io_supply_ok_i & core_supply_ok_i & primary_supply_ok_i;

  assign dev_hit = bus_dev_sel_i == addr_pins_i;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wel_r <= 1'b0;
      shutdown_r <= `TPS_SHUTDOWN_RESET;
      bus_wr_ack_o <= 1'b0;
    end else if (en_i) begin
      bus_wr_ack_o <= 1'b0;
      if (bus_we_i && dev_hit) begin
        if (bus_addr_i == `TPS_ADDR_STATUS) begin
          wel_r <= bus_wdata_i == `TPS_WEL_SET_VALUE;
          bus_wr_ack_o <= 1'b1;
        end else if (bus_addr_i == `TPS_ADDR_SHUTDOWN && wel_r) begin
          shutdown_r <= bus_wdata_i;
          bus_wr_ack_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata_o <= '0;
    end else if (en_i) begin
      bus_rdata_o <= '0;
      if (bus_re_i && dev_hit) begin
        if (bus_addr_i == `TPS_ADDR_STATUS) begin
          bus_rdata_o[`TPS_STAT_PRIMARY_BIT] <= primary_gate_o;
          bus_rdata_o[`TPS_STAT_IO_BIT] <= io_gate_o;
          bus_rdata_o[`TPS_STAT_CORE_BIT] <= core_gate_o;
          bus_rdata_o[`TPS_STAT_WEL_BIT] <= wel_r;
        end else if (bus_addr_i == `TPS_ADDR_SHUTDOWN) begin
          bus_rdata_o <= shutdown_r;
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_enter_down;
    en_i && state_r == TPS_ALL_ON && !supplies_lost && (!want_on || !io_supply_ok_i);
  endsequence

  sequence s_io_off_core_held;
    !io_r && core_r && state_r == TPS_CORE_DOWN;
  endsequence

  a_pg_holdoff: assert property ($rose(pg_r) |-> hold_cnt_r == HOLDOFF_LIM)
    else $error("power good rose before hold-off elapsed");
  a_pg_drop_now: assert property (!primary_supply_ok_i |-> !power_good_o)
    else $error("power good stayed high with primary supply low");
  a_primary_follow: assert property (primary_gate_enable_i && primary_supply_ok_i && !primary_off
    |-> primary_gate_o)
    else $error("primary gate not on with its enable high");
  a_core_needs_pg: assert property ($rose(core_r) |-> $past(pg_r))
    else $error("core sequencing began without power good");
  a_io_lockout: assert property (!io_supply_ok_i |-> !io_gate_o)
    else $error("io gate on below io lockout");
  a_ens_core_on: assert property (en_i && state_r == TPS_IDLE && ens_rise && !supplies_lost && !io_core_off
    |=> core_r)
    else $error("enable rising edge did not start core gate");
  a_time_up_wait: assert property ($rose(io_r) && mode_r == TPS_MODE_TIME |-> seq_cnt_r == UP_LIM)
    else $error("io gate on before up delay");
  a_down_seq: assert property (s_enter_down |=> s_io_off_core_held)
    else $error("io off with core held did not follow stop");
  a_voltage_sequence_set_in_core_on: assert property (en_i && state_r == TPS_IDLE && voltage_sequence_set_in_rise && !ens_rise && !supplies_lost
    && !io_core_off |=> core_r)
    else $error("set rising edge did not start core gate");
  a_volt_io_on: assert property ($rose(io_r) && mode_r == TPS_MODE_VOLTAGE |-> $past(fb_above_r))
    else $error("io gate on without feedback above reference");
  a_hysteresis: assert property ($fell(fb_above_r) |-> $past(core_feedback_i) + HYST_LSB
    < $past(core_reference_i))
    else $error("comparator released inside hysteresis band");
  a_down_hold: assert property (state_r == TPS_CORE_DOWN && seq_cnt_r < DOWN_LIM && !supplies_lost
    |-> core_r)
    else $error("core gate dropped before down delay");
  a_primary_fail: assert property (!primary_supply_ok_i |-> !primary_gate_o && !io_gate_o && !core_gate_o)
    else $error("a gate stayed on after primary failure");
  a_core_fail: assert property (!core_supply_ok_i |-> !core_gate_o && !io_gate_o)
    else $error("core or io gate on after core failure");
  a_status_read: assert property (en_i && bus_re_i && dev_hit && bus_addr_i == `TPS_ADDR_STATUS
    |=> bus_rdata_o[3:1] == $past({primary_gate_o, io_gate_o, core_gate_o}))
    else $error("status bits differ from gate controls");
  a_wel_block: assert property (en_i && bus_we_i && bus_addr_i == `TPS_ADDR_SHUTDOWN && !wel_r
    |=> shutdown_r == $past(shutdown_r) && !bus_wr_ack_o)
    else $error("shutdown write taken with latch clear");

endmodule

// *** design/tps_defs.svh ***
`ifndef TPS_DEFS_SVH
`define TPS_DEFS_SVH

`define TPS_CLK_PERIOD_NS 10

`define TPS_HOLDOFF_US 100
`define TPS_SEQ_UP_US 50
`define TPS_SEQ_DOWN_US 50

`define TPS_ADDR_W 8
`define TPS_DATA_W 8
`define TPS_ADDR_STATUS 8'h00
`define TPS_ADDR_SHUTDOWN 8'hFF

`define TPS_STAT_PRIMARY_BIT 3
`define TPS_STAT_IO_BIT 2
`define TPS_STAT_CORE_BIT 1
`define TPS_STAT_WEL_BIT 0

`define TPS_WEL_SET_VALUE 8'h01
`define TPS_SHUTDOWN_RESET 8'h00
`define TPS_SD_NONE 2'h0
`define TPS_SD_IO_CORE 2'h1
`define TPS_SD_PRIMARY 2'h2
`define TPS_SD_ALL 2'h3

`define TPS_FB_W 10
`define TPS_HYST_LSB 10'h01E

`endif

// *** design/tps_pkg.sv ***
package tps_pkg;

  typedef enum logic [1:0] {
    TPS_IDLE,
    TPS_CORE_UP,
    TPS_ALL_ON,
    TPS_CORE_DOWN
  } tps_state_t;

  typedef enum logic {
    TPS_MODE_TIME,
    TPS_MODE_VOLTAGE
  } tps_mode_t;

endpackage

// *** tb/tps_rail_model.sv ***
module tps_rail_model (
  input wire logic clk_i,
  input wire logic core_gate_i,
  output logic [9:0] core_feedback_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] fb_r = 10'h000;
  assign core_feedback_o = fb_r;
  // The rail charges slowly while its gate is on, so the comparator sees a ramp, not a step.
  always @(posedge clk_i) begin
    if (core_gate_i) begin
      fb_r <= (fb_r > 10'h3EF) ? 10'h3FF : fb_r + 10'h010;
    end else begin
      fb_r <= (fb_r < 10'h010) ? 10'h000 : fb_r - 10'h010;
    end
  end
endmodule

// *** tb/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 8;
  localparam int UP = 6;
  localparam int DN = 5;
  logic clk, nrst, p_ok, io_ok, c_ok, pge, seq_en, vset, we, re, rd_pend, ack, pg, g_p, g_io, g_c;
  logic [9:0] fb, ref_v;
  logic [2:0] pins, sel, gates, mid;
  logic [7:0] addr, wdata, rdata, v;
  logic [7:0] notes[$];
  int err_total, comparisons, cyc;
  assign gates = {g_p, g_io, g_c};

  tps_seq #(.HOLDOFF_CYC(HOLD), .SEQ_UP_CYC(UP), .SEQ_DOWN_CYC(DN)) DUT (
    .clk_i(clk), .nrst_i(nrst), .en_i(1'b1), .primary_supply_ok_i(p_ok), .io_supply_ok_i(io_ok),
    .core_supply_ok_i(c_ok), .primary_gate_enable_i(pge), .sequence_enable_i(seq_en),
    .voltage_sequence_set_i(vset), .core_feedback_i(fb), .core_reference_i(ref_v), .addr_pins_i(pins),
    .bus_dev_sel_i(sel), .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_we_i(we), .bus_re_i(re),
    .bus_rdata_o(rdata), .bus_wr_ack_o(ack), .power_good_o(pg), .primary_gate_o(g_p),
    .io_gate_o(g_io), .core_gate_o(g_c));
  tps_rail_model rail (.clk_i(clk), .core_gate_i(g_c), .core_feedback_o(fb));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp_bus(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_gates(input logic [2:0] exp);
    cmp_bus({5'h00, gates}, {5'h00, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic settle(input logic [2:0] exp, input int n);
    for (int i = 0; i < n && gates !== exp; i++) begin
      @(negedge clk);
    end
    cmp_gates(exp);
  endtask

  task automatic hold(input logic [2:0] exp, input int n);
    repeat (n) begin
      @(negedge clk);
      cmp_gates(exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ack_exp);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(negedge clk);
    cmp_bus({7'h00, ack}, {7'h00, ack_exp});
  endtask

  // The expected byte is queued here and taken off by the watcher when the data stand.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    notes.push_back(exp);
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
  endtask

  // Stopping waits out the down delay so a new rising edge starts from idle.
  task automatic restart();
    @(posedge clk);
    seq_en <= 1'b0;
    tick(DN + 4);
    @(posedge clk);
    io_ok <= 1'b1;
    c_ok <= 1'b1;
    tick(2);
    @(posedge clk);
    seq_en <= 1'b1;
    settle(3'h7, UP + 8);
  endtask

  always @(posedge clk) rd_pend <= re;
  always @(negedge clk) begin
    if (rd_pend === 1'b1) begin
      cmp_bus(rdata, notes.pop_front());
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    {p_ok, io_ok, c_ok, pge, seq_en, vset, we, re} = 8'h00;
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    err_total = 0;
    comparisons = 0;
    cyc = 0;
    void'($urandom(64574));
    pins = 3'($urandom);
    sel = pins;
    ref_v = 10'h080 + 10'($urandom % 64);
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    tick(4);
    cmp_gates(3'h0);
    rd(8'h00, 8'h00);
    wr(8'hFF, 8'h01, 1'b0);
    rd(8'hFF, 8'h00);
    @(posedge clk);
    p_ok <= 1'b1;
    io_ok <= 1'b1;
    c_ok <= 1'b1;
    pge <= 1'b1;
    settle(3'h4, 3);
    repeat (HOLD - 1) begin
      @(negedge clk);
      cmp_bus({7'h00, pg}, 8'h00);
    end
    for (int i = 0; i < 6 && pg !== 1'b1; i++) begin
      @(negedge clk);
    end
    cmp_bus({7'h00, pg}, 8'h01);
    @(posedge clk);
    seq_en <= 1'b1;
    settle(3'h5, 3);
    hold(3'h5, UP - 1);
    settle(3'h7, 4);
    rd(8'h00, 8'h0E);
    @(posedge clk);
    seq_en <= 1'b0;
    settle(3'h5, 3);
    hold(3'h5, DN - 1);
    settle(3'h4, 4);
    // The rail is still charged from the timed run; let it drain so the comparator starts below the reference.
    tick(64);
    @(posedge clk);
    vset <= 1'b1;
    settle(3'h5, 3);
    hold(3'h5, 4);
    settle(3'h7, 40);
    cmp_bus({7'h00, fb > ref_v}, 8'h01);
    @(posedge clk);
    vset <= 1'b0;
    settle(3'h5, 3);
    hold(3'h5, DN - 1);
    settle(3'h4, 4);
    v = 8'h01 + 8'($urandom % 254);
    wr(v, 8'h01, 1'b0);
    rd(v, 8'h00);
    @(posedge clk);
    sel <= pins ^ 3'h4;
    wr(8'h00, 8'h01, 1'b0);
    @(posedge clk);
    sel <= pins;
    wr(8'h00, 8'h01, 1'b1);
    rd(8'h00, 8'h09);
    restart();
    for (int c = 1; c < 4; c++) begin
      mid = (c == 1) ? 3'h5 : (c == 2) ? 3'h3 : 3'h1;
      wr(8'hFF, 8'(c), 1'b1);
      settle(mid, 3);
      hold(mid, DN - 1);
      settle(mid & ((c == 2) ? 3'h7 : 3'h6), 4);
      rd(8'hFF, 8'(c));
      wr(8'hFF, 8'h00, 1'b1);
      settle(3'h7, UP + 8);
    end
    v = 8'($urandom) | 8'h02;
    wr(8'h00, v, 1'b1);
    wr(8'hFF, 8'h02, 1'b0);
    cmp_gates(3'h7);
    @(posedge clk);
    io_ok <= 1'b0;
    settle(3'h5, 2);
    hold(3'h5, DN - 1);
    settle(3'h4, 4);
    hold(3'h4, 3);
    restart();
    @(posedge clk);
    c_ok <= 1'b0;
    @(negedge clk);
    cmp_gates(3'h4);
    rd(8'h00, 8'h08);
    restart();
    @(posedge clk);
    p_ok <= 1'b0;
    @(negedge clk);
    cmp_gates(3'h0);
    cmp_bus({7'h00, pg}, 8'h00);
    print_verdict();
  end
endmodule
